// >>> design/cidf_pkg.sv
/*
 * Shared constants and types of the CAN identifier acceptance filter.
 * Assumes one 25 MHz clock and a 32-bit APB register bus.
 */
package cidf_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int ID_W = 29;
  localparam int STD_W = 11;
  localparam int ENT_N = 32;
  localparam int MEM_AW = 6;
  localparam int MEM_DW = 64;
  localparam int ENA_BIT = 0;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_IDX = 8'h08;
  localparam logic [7:0] OFF_ENT_LO = 8'h0c;
  localparam logic [7:0] OFF_ENT_HI = 8'h10;
  localparam logic [5:0] IDX_RST = 6'h00;
  localparam logic [5:0] ENA_ADDR = 6'h20;
  localparam logic [31:0] LO_RST = 32'h0000_0000;

  // ************************************************************
  // Mode switch and timing
  // ************************************************************
  localparam logic [3:0] SW_UPD = 4'he;
  localparam logic [3:0] SW_CFG = 4'hf;
  localparam logic [3:0] ROT_RST = 4'h1;
  localparam int CLK_HZ = 25_000_000;
  localparam int BLINK_MS = 500;
  localparam int STEP_MS = 500;
  localparam int HALF_CYC = CLK_HZ / 1000 * BLINK_MS / 2;
  localparam int STEP_TICKS = STEP_MS / (BLINK_MS / 2);

  typedef enum logic [1:0] {MODE_RUN, MODE_CFG, MODE_UPD} cidf_mode_t;

  typedef struct packed {
    logic port;
    logic ext;
    logic [ID_W-1:0] id;
  } cidf_frame_t;

  typedef struct packed {
    logic valid;
    logic port;
    logic rsv1;
    logic [ID_W-1:0] hi;
    logic group;
    logic ext;
    logic rsv0;
    logic [ID_W-1:0] lo;
  } cidf_entry_t;

endpackage

// >>> design/cidf_tbl_mem.sv
/*
 * Filter table storage: one port, registered read data.
 * Assumes contents survive a reset, like the nonvolatile store it models.
 */
`timescale 1ns/1ps
module cidf_tbl_mem (
  input wire logic pclk,
  input wire logic we,
  input wire logic [cidf_pkg::MEM_AW-1:0] addr,
  input wire logic [cidf_pkg::MEM_DW-1:0] wdata,
  output logic [cidf_pkg::MEM_DW-1:0] rdata
);
  logic [cidf_pkg::MEM_DW-1:0] mem [2**cidf_pkg::MEM_AW];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule // cidf_tbl_mem

// >>> design/cidf_fifo2.sv
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes a single clock and an active-low asynchronous reset.
 */
`timescale 1ns/1ps
module cidf_fifo2 #(
  parameter int W = 31
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  logic [W-1:0] slot_reg [2];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready = (cnt_reg != 2'h2);
  assign out_valid = (cnt_reg != 2'h0);
  assign out_data = slot_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_reg[0] <= '0;
      slot_reg[1] <= '0;
      wr_ptr_reg <= 1'b0;
    end else if (push) begin
      slot_reg[wr_ptr_reg] <= in_data;
      wr_ptr_reg <= ~wr_ptr_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_ptr_reg <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // cidf_fifo2

// >>> design/cidf_filter.sv
/*
 * Identifier acceptance filter with APB access to its table, mode
 * selection from the rotary switch and status indicator driving.
 * Assumes frames arrive decoded, synchronous to pclk, and that the
 * switch is stable across reset.
 */
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module cidf_filter #(
  parameter int TICK_CYC = cidf_pkg::HALF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] mode_sw,
  input wire logic [3:0] run_led,
  input wire logic in_valid,
  input wire cidf_pkg::cidf_frame_t in_frame,
  output logic in_ready,
  output logic out_valid,
  output cidf_pkg::cidf_frame_t out_frame,
  input wire logic out_ready,
  output logic [3:0] led,
  output logic fw_mode
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [cidf_pkg::ID_W-1:0] id_cut(
    input logic ext, input logic [cidf_pkg::ID_W-1:0] v);
    id_cut = ext ? v : {18'h0, v[cidf_pkg::STD_W-1:0]};
  endfunction

  function automatic logic hit_f(input cidf_pkg::cidf_entry_t e,
    input cidf_pkg::cidf_frame_t f);
    logic [cidf_pkg::ID_W-1:0] id;
    logic [cidf_pkg::ID_W-1:0] lo;
    logic [cidf_pkg::ID_W-1:0] hi;
    id = id_cut(f.ext, f.id);
    lo = id_cut(e.ext, e.lo);
    hi = id_cut(e.ext, e.hi);
    hit_f = e.valid && (e.port == f.port)
      && (e.ext == f.ext)
      && (e.group ? (id >= lo && id <= hi) : (id == lo));
  endfunction

  typedef enum logic [2:0] {
    ST_STRAP, ST_BOOT, ST_LOAD, ST_IDLE, ST_RD, ST_CMP, ST_PUSH
  } cidf_state_t;

  cidf_state_t state_reg;
  cidf_pkg::cidf_mode_t mode_reg;
  cidf_pkg::cidf_frame_t frm_reg;
  cidf_pkg::cidf_entry_t ent;
  logic act_en_reg;
  logic [cidf_pkg::MEM_AW-1:0] scan_reg;
  logic [5:0] idx_reg;
  logic [31:0] lo_stage_reg;
  logic [31:0] prdata_reg;
  logic ack_reg;
  logic mem_we;
  logic [cidf_pkg::MEM_AW-1:0] mem_addr;
  logic [cidf_pkg::MEM_DW-1:0] mem_wdata;
  logic [cidf_pkg::MEM_DW-1:0] mem_rdata;
  logic fifo_valid;
  logic fifo_ready;
  logic hit;
  logic wr_done;
  logic mapped;
  logic [31:0] tick_cnt_reg;
  logic tick;
  logic step_reg;
  logic [3:0] led_reg;

  assign ent = cidf_pkg::cidf_entry_t'(mem_rdata);
  assign hit = hit_f(ent, frm_reg);

  // ************************************************************
  // Mode capture at power-up
  // ************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= cidf_pkg::MODE_RUN;
    end else if (state_reg == ST_STRAP) begin
      if (mode_sw == cidf_pkg::SW_UPD) begin
        mode_reg <= cidf_pkg::MODE_UPD;
      end else if (mode_sw == cidf_pkg::SW_CFG) begin
        mode_reg <= cidf_pkg::MODE_CFG;
      end else begin
        mode_reg <= cidf_pkg::MODE_RUN;
      end
    end
  end

  assign fw_mode = (mode_reg == cidf_pkg::MODE_UPD);

  // ************************************************************
  // Frame path
  // ************************************************************
  // The frame path addresses the table only in run mode and APB addresses
  // it only outside run mode, so the single memory port is never contended.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_STRAP;
      scan_reg <= '0;
      frm_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_STRAP: begin
          state_reg <= ST_BOOT;
        end
        ST_BOOT: begin
          state_reg <= (mode_reg == cidf_pkg::MODE_RUN) ? ST_LOAD : ST_IDLE;
        end
        ST_LOAD: begin
          state_reg <= ST_IDLE;
        end
        ST_IDLE: begin
          if (in_valid && mode_reg == cidf_pkg::MODE_RUN) begin
            frm_reg <= in_frame;
            scan_reg <= '0;
            state_reg <= act_en_reg ? ST_RD : ST_PUSH;
          end
        end
        ST_RD: begin
          state_reg <= ST_CMP;
        end
        ST_CMP: begin
          if (hit) begin
            state_reg <= ST_PUSH;
          end else if (scan_reg == 6'(cidf_pkg::ENT_N - 1)) begin
            state_reg <= ST_IDLE;
          end else begin
            scan_reg <= scan_reg + 6'h01;
            state_reg <= ST_RD;
          end
        end
        ST_PUSH: begin
          if (fifo_ready) begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // The enable word is taken from storage once, at power-up in run mode only.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_en_reg <= 1'b0;
    end else if (state_reg == ST_LOAD) begin
      act_en_reg <= mem_rdata[cidf_pkg::ENA_BIT];
    end
  end

  // Frames offered outside run mode are taken and discarded.
  assign in_ready = (state_reg == ST_IDLE);
  assign fifo_valid = (state_reg == ST_PUSH);

  cidf_fifo2 #(.W($bits(cidf_pkg::cidf_frame_t))) u_buf (
    .pclk(pclk),
    .presetn(presetn),
    .in_valid(fifo_valid),
    .in_data(frm_reg),
    .in_ready(fifo_ready),
    .out_valid(out_valid),
    .out_data(out_frame),
    .out_ready(out_ready)
  );

  // ************************************************************
  // Table storage
  // ************************************************************
  assign wr_done = psel && penable && ack_reg && pwrite;
  assign mem_we = wr_done && (mode_reg == cidf_pkg::MODE_CFG)
    && (paddr == cidf_pkg::OFF_CTRL || paddr == cidf_pkg::OFF_ENT_HI);
  assign mem_wdata = (paddr == cidf_pkg::OFF_CTRL)
    ? {32'h0, pwdata} : {pwdata, lo_stage_reg};

  always_comb begin
    if (mode_reg == cidf_pkg::MODE_RUN) begin
      mem_addr = (state_reg == ST_BOOT || state_reg == ST_LOAD)
        ? cidf_pkg::ENA_ADDR : scan_reg;
    end else if (mem_we && paddr == cidf_pkg::OFF_CTRL) begin
      mem_addr = cidf_pkg::ENA_ADDR;
    end else begin
      mem_addr = idx_reg;
    end
  end

  cidf_tbl_mem u_mem (
    .pclk(pclk),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  // ************************************************************
  // APB slave
  // ************************************************************
  // One wait state so that read data leave a flip-flop.
  assign mapped = (paddr == cidf_pkg::OFF_CTRL)
    || (paddr == cidf_pkg::OFF_STATUS) || (paddr == cidf_pkg::OFF_IDX)
    || (paddr == cidf_pkg::OFF_ENT_LO) || (paddr == cidf_pkg::OFF_ENT_HI);
  assign pready = ack_reg;
  assign prdata = prdata_reg;
  assign pslverr = ack_reg && (!mapped || (pwrite
    && mode_reg != cidf_pkg::MODE_CFG && paddr != cidf_pkg::OFF_IDX));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= psel && penable && !ack_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
    end else if (psel && penable && !ack_reg && !pwrite) begin
      unique case (paddr)
        cidf_pkg::OFF_CTRL: prdata_reg <= {31'h0, act_en_reg};
        cidf_pkg::OFF_STATUS: prdata_reg <= {27'h0,
          state_reg, 2'(mode_reg)};
        cidf_pkg::OFF_IDX: prdata_reg <= {26'h0, idx_reg};
        cidf_pkg::OFF_ENT_LO: prdata_reg <= mem_rdata[31:0];
        cidf_pkg::OFF_ENT_HI: prdata_reg <= mem_rdata[63:32];
        default: prdata_reg <= '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_reg <= cidf_pkg::IDX_RST;
      lo_stage_reg <= cidf_pkg::LO_RST;
    end else if (wr_done) begin
      if (paddr == cidf_pkg::OFF_IDX) begin
        idx_reg <= pwdata[5:0];
      end
      if (paddr == cidf_pkg::OFF_ENT_LO) begin
        lo_stage_reg <= pwdata;
      end
    end
  end

  // ************************************************************
  // Indicators
  // ************************************************************
  assign tick = (tick_cnt_reg == 32'(TICK_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= '0;
      step_reg <= 1'b0;
    end else if (tick) begin
      tick_cnt_reg <= '0;
      step_reg <= ~step_reg;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_reg <= 4'h0;
    end else if (state_reg == ST_BOOT) begin
      led_reg <= (mode_reg == cidf_pkg::MODE_CFG) ? cidf_pkg::ROT_RST : 4'h0;
    end else begin
      unique case (mode_reg)
        cidf_pkg::MODE_RUN: led_reg <= run_led;
        cidf_pkg::MODE_UPD: begin
          if (tick) begin
            led_reg <= ~led_reg;
          end
        end
        cidf_pkg::MODE_CFG: begin
          if (tick && step_reg) begin
            led_reg <= {led_reg[2:0], led_reg[3]};
          end
        end
      endcase
    end
  end

  assign led = led_reg;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  miss_drop_a: assert property ((state_reg == ST_CMP && !hit)
    |=> state_reg != ST_PUSH) else $error("missed frame forwarded");
  single_eq_a: assert property ((state_reg == ST_CMP && ent.valid
    && !ent.group && ent.port == frm_reg.port && ent.ext == frm_reg.ext
    && id_cut(ent.ext, ent.lo) == id_cut(frm_reg.ext, frm_reg.id))
    |=> state_reg == ST_PUSH) else $error("equal id not forwarded");
  group_end_a: assert property ((state_reg == ST_CMP && ent.valid
    && ent.group && ent.port == frm_reg.port && ent.ext == frm_reg.ext
    && id_cut(ent.ext, ent.hi) == id_cut(frm_reg.ext, frm_reg.id)
    && id_cut(ent.ext, ent.lo) <= id_cut(ent.ext, ent.hi))
    |=> state_reg == ST_PUSH) else $error("group end not inclusive");
  fmt_sep_a: assert property ((ent.ext != frm_reg.ext) |-> !hit)
    else $error("format mismatch matched");
  ext_full_a: assert property ((ent.valid && ent.ext && frm_reg.ext
    && !ent.group && ent.port == frm_reg.port && ent.lo != frm_reg.id)
    |-> !hit) else $error("extended id compared short");
  port_tag_a: assert property ((ent.port != frm_reg.port) |-> !hit)
    else $error("entry applied to other port");
  bypass_all_a: assert property ((state_reg == ST_IDLE && in_valid
    && mode_reg == cidf_pkg::MODE_RUN && !act_en_reg)
    |=> state_reg == ST_PUSH) else $error("unfiltered frame dropped");
  en_fixed_a: assert property ((state_reg != ST_LOAD)
    |=> $stable(act_en_reg)) else $error("enable changed after boot");
  upd_quiet_a: assert property ((mode_reg == cidf_pkg::MODE_UPD)
    |-> !fifo_valid && !mem_we) else $error("update mode relays");
  blink_flip_a: assert property ((mode_reg == cidf_pkg::MODE_UPD
    && tick && state_reg == ST_IDLE) |=> led == ~$past(led))
    else $error("update blink wrong");
  rot_step_a: assert property ((mode_reg == cidf_pkg::MODE_CFG
    && tick && step_reg && state_reg == ST_IDLE)
    |=> led == {$past(led[2:0]), $past(led[3])})
    else $error("rotation wrong");
  cfg_write_a: assert property (mem_we
    |-> mode_reg == cidf_pkg::MODE_CFG) else $error("table written late");

endmodule // cidf_filter

// >>> bench/cidf_sink.sv
/*
 * Far-side model of the acceptance filter: a receiver of forwarded frames
 * that logs every word it takes and can stall or run at half rate.
 * Assumes the filter's valid/ready output handshake on pclk.
 */
`timescale 1ns/1ps
module cidf_sink (
  input wire logic pclk,
  input wire logic out_valid,
  input wire cidf_pkg::cidf_frame_t out_frame,
  output logic out_ready,
  input wire logic slow,
  input wire logic hold
);
  cidf_pkg::cidf_frame_t got[$];
  initial out_ready = 1'b0;
  // A slow receiver takes at most one word every other cycle, so a word can wait in the buffer.
  always @(posedge pclk) begin
    if (out_valid && out_ready) begin
      got.push_back(out_frame);
    end
    out_ready <= !hold && !(slow && out_ready);
  end
endmodule // cidf_sink

// >>> bench/cidf_filter_test.sv
/*
 * Self-checking testbench of the acceptance filter: APB table set-up,
 * filtered and unfiltered forwarding, back-pressure and switch modes.
 * Assumes the table store survives reset, as a power cycle does.
 */
`timescale 1ns/1ps
module cidf_filter_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] mode_sw, run_led, led;
  logic in_valid, in_ready, out_valid, out_ready, fw_mode, slow, hold;
  logic ok, err;
  cidf_pkg::cidf_frame_t in_frame, out_frame;
  cidf_pkg::cidf_frame_t exp_q[$];
  int n_mismatch = 0;
  int n_tests = 0;
  int acc;
  localparam logic [31:0] E_LO[2] = '{32'h4000_007f, 32'h8000_0004};
  localparam logic [31:0] E_HI[2] = '{32'h8000_007f, 32'hc000_0015};
  // Each word is {forwarded, port, extended, identifier}.
  localparam logic [31:0] FR[10] = '{32'ha000_007f, 32'h0000_007f,
    32'h6000_0004, 32'hc000_0004, 32'hc000_0015, 32'h4000_0016,
    32'h4000_0003, 32'h0000_0004, 32'h6000_007f, 32'h3000_007f};

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  cidf_filter #(.TICK_CYC(8)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mode_sw(mode_sw), .run_led(run_led), .in_valid(in_valid),
    .in_frame(in_frame), .in_ready(in_ready), .out_valid(out_valid),
    .out_frame(out_frame), .out_ready(out_ready), .led(led),
    .fw_mode(fw_mode));
  cidf_sink snk (.pclk(pclk), .out_valid(out_valid), .out_frame(out_frame),
    .out_ready(out_ready), .slow(slow), .hold(hold));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task give_verdict;
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // The switch is set only while the device is held off.
  task power_up(input logic [3:0] sw);
    @(posedge pclk);
    mode_sw <= sw;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask

  // The request is withdrawn only once taken; a refused one stays up.
  task send(input logic [30:0] f, input int lim);
    int k;
    @(posedge pclk);
    in_valid <= 1'b1;
    in_frame <= f;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
      ok = in_ready;
    end while (ok !== 1'b1 && k < lim);
    if (ok === 1'b1) begin
      in_valid <= 1'b0;
      in_frame <= ~f;
    end
  endtask

  task led_steps(input int per, input logic inv);
    logic [3:0] prev;
    logic [3:0] want;
    int k;
    for (int s = 0; s < 4; s++) begin
      prev = led;
      k = 0;
      do begin
        @(posedge pclk);
        k++;
      end while (led === prev && k < 40);
      // The expected pattern is kept at four bits before it is widened.
      want = inv ? ~prev : {prev[2:0], prev[3]};
      if (s > 1) begin
        chk(k, per);
        chk(led, want);
      end
    end
  endtask

  task drain_check;
    repeat (150) @(posedge pclk);
    chk(snk.got.size(), exp_q.size());
    foreach (exp_q[i]) begin
      chk(snk.got[i], exp_q[i]);
    end
    snk.got.delete();
    exp_q.delete();
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task t_config;
    power_up(cidf_pkg::SW_CFG);
    apb(1'b0, cidf_pkg::OFF_STATUS, 32'h0);
    chk(rd[1:0], 2'h1);
    chk(fw_mode, 1'b0);
    led_steps(16, 1'b0);
    apb(1'b0, 8'h14, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    for (int i = 0; i < 32; i++) begin
      apb(1'b1, cidf_pkg::OFF_IDX, 32'(i));
      apb(1'b1, cidf_pkg::OFF_ENT_LO, i < 2 ? E_LO[i] : 32'h0);
      apb(1'b1, cidf_pkg::OFF_ENT_HI, i < 2 ? E_HI[i] : 32'h0);
    end
    apb(1'b1, cidf_pkg::OFF_CTRL, 32'h1);
    chk(err, 1'b0);
    apb(1'b0, cidf_pkg::OFF_CTRL, 32'h0);
    chk(rd[0], 1'b0);
    apb(1'b1, cidf_pkg::OFF_IDX, {26'h0, cidf_pkg::ENA_ADDR});
    apb(1'b0, cidf_pkg::OFF_ENT_LO, 32'h0);
    chk(rd[0], 1'b1);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, cidf_pkg::OFF_IDX, 32'(i));
      apb(1'b0, cidf_pkg::OFF_ENT_LO, 32'h0);
      chk(rd, E_LO[i]);
      apb(1'b0, cidf_pkg::OFF_ENT_HI, 32'h0);
      chk(rd, E_HI[i]);
    end
  endtask

  task t_filter_on;
    power_up(4'h0);
    apb(1'b0, cidf_pkg::OFF_CTRL, 32'h0);
    chk(rd[0], 1'b1);
    apb(1'b1, cidf_pkg::OFF_CTRL, 32'h0);
    chk(err, 1'b1);
    run_led <= 4'ha;
    repeat (3) @(posedge pclk);
    chk(led, 4'ha);
    slow <= 1'b1;
    for (int j = 0; j < 10; j++) begin
      send(FR[j][30:0], 100);
      if (FR[j][31])
        exp_q.push_back(FR[j][30:0]);
    end
    drain_check();
  endtask

  task t_filter_off;
    power_up(cidf_pkg::SW_CFG);
    apb(1'b1, cidf_pkg::OFF_CTRL, 32'h0);
    power_up(4'h0);
    apb(1'b0, cidf_pkg::OFF_CTRL, 32'h0);
    chk(rd[0], 1'b0);
    slow <= 1'b0;
    hold <= 1'b1;
    acc = 0;
    do begin
      send(31'(32'h40 + acc), 20);
      if (ok === 1'b1) begin
        exp_q.push_back(31'(32'h40 + acc));
        acc++;
      end
    end while (ok === 1'b1 && acc < 6);
    chk(acc >= 2 && acc < 6, 1'b1);
    hold <= 1'b0;
    send(31'(32'h40 + acc), 100);
    chk(ok, 1'b1);
    exp_q.push_back(31'(32'h40 + acc));
    drain_check();
  endtask

  task t_update;
    power_up(cidf_pkg::SW_UPD);
    chk(fw_mode, 1'b1);
    apb(1'b0, cidf_pkg::OFF_STATUS, 32'h0);
    chk(rd[1:0], 2'h2);
    led_steps(8, 1'b1);
    send(FR[0][30:0], 40);
    drain_check();
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mode_sw = 4'h0;
    run_led = 4'h5;
    in_valid = 1'b0;
    in_frame = '0;
    slow = 1'b0;
    hold = 1'b0;
    t_config();
    t_filter_on();
    t_filter_off();
    t_update();
    give_verdict();
  end

  // A hang anywhere ends the run through the same verdict.
  initial begin
    repeat (30000) @(posedge pclk);
    n_mismatch++;
    give_verdict();
  end
endmodule // cidf_filter_test
